/* src/ssp_ctrl.sv */
// Self sector programming controller: Avalon-MM registers and unlock sequence
`timescale 1ns/1ps
module ssp_ctrl #(
    parameter logic [5:0] LAST_SECTOR = ssp_pkg::LAST_SECTOR
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [ssp_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [ssp_pkg::DATA_W-1:0] avs_writedata,
    output logic [ssp_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic flashEraseReq,
    output logic flashProgReq,
    output logic [ssp_pkg::FLASH_ADDR_W-1:0] flashAddr,
    output logic [7:0] flashData,
    input wire logic flashDone,
    output logic cpuIdle
);
    if (LAST_SECTOR == 6'h00) begin : g_chk
        $error("LAST_SECTOR must be above zero");
    end

    ssp_flash_if fif ();

    logic [7:0] opType_ff, nxt_opType;
    logic [3:0] key1_ff, nxt_key1;
    logic [3:0] key2_ff, nxt_key2;
    logic [3:0] key3_ff, nxt_key3;
    logic [3:0] key4_ff, nxt_key4;
    logic [7:0] page_ff, nxt_page;
    logic [7:0] offset_ff, nxt_offset;
    logic [7:0] data_ff, nxt_data;
    logic [7:0] aux_ff, nxt_aux;
    logic abort_ff, nxt_abort;
    logic refused_ff, nxt_refused;
    logic doneFlag_ff, nxt_doneFlag;
    logic start_ff, nxt_start;
    logic erase_ff, nxt_erase;
    ssp_pkg::ssp_seq_t seq_ff, nxt_seq;
    logic resp_ff, nxt_resp;
    logic [7:0] rdData_ff, nxt_rdData;
    logic req;
    logic stallWr;
    logic wrAcc;
    logic [7:0] idx;
    logic [7:0] wByte;
    logic [3:0] wNib;
    logic [7:0] status;

    // One wait cycle per access; writes stall while an operation is pending
    assign req = avs_read || avs_write;
    assign stallWr = avs_write && (fif.busy || start_ff);
    assign avs_waitrequest = req && !resp_ff;
    assign wrAcc = avs_write && resp_ff && avs_byteenable[0];
    assign idx = avs_address[ssp_pkg::IDX_HI:ssp_pkg::IDX_LO];
    assign wByte = avs_writedata[7:0];
    assign wNib = avs_writedata[3:0];
    assign status = {4'h0, doneFlag_ff, refused_ff, abort_ff, fif.busy};

    // Bus handshake and registered read data
    always_comb begin
        nxt_resp = req && !resp_ff && !stallWr;
        nxt_rdData = rdData_ff;
        if (avs_read && !resp_ff) begin
            if (idx == ssp_pkg::IDX_OP_TYPE) begin
                nxt_rdData = opType_ff;
            end else if (idx == ssp_pkg::IDX_UNLOCK1) begin
                nxt_rdData = {4'h0, key1_ff};
            end else if (idx == ssp_pkg::IDX_UNLOCK2) begin
                nxt_rdData = {4'h0, key2_ff};
            end else if (idx == ssp_pkg::IDX_UNLOCK3) begin
                nxt_rdData = {4'h0, key3_ff};
            end else if (idx == ssp_pkg::IDX_UNLOCK4) begin
                nxt_rdData = {4'h0, key4_ff};
            end else if (idx == ssp_pkg::IDX_PAGE) begin
                nxt_rdData = page_ff;
            end else if (idx == ssp_pkg::IDX_STATUS) begin
                nxt_rdData = status;
            end else if (idx == ssp_pkg::IDX_OFFSET) begin
                nxt_rdData = offset_ff;
            end else if (idx == ssp_pkg::IDX_DATA) begin
                nxt_rdData = data_ff;
            end else if (idx == ssp_pkg::IDX_AUX) begin
                nxt_rdData = aux_ff;
            end else begin
                nxt_rdData = ssp_pkg::REG_RESET; // Unmapped reads as zero
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            resp_ff <= 1'b0;
            rdData_ff <= ssp_pkg::REG_RESET;
        end else begin
            resp_ff <= nxt_resp;
            rdData_ff <= nxt_rdData;
        end
    end

    // Register writes and the unlock sequence tracker
    always_comb begin
        nxt_opType = opType_ff;
        nxt_key1 = key1_ff;
        nxt_key2 = key2_ff;
        nxt_key3 = key3_ff;
        nxt_key4 = key4_ff;
        nxt_page = page_ff;
        nxt_offset = offset_ff;
        nxt_data = data_ff;
        nxt_aux = aux_ff;
        nxt_seq = seq_ff;
        nxt_start = 1'b0;
        nxt_erase = erase_ff;
        nxt_abort = abort_ff;
        nxt_refused = refused_ff;
        nxt_doneFlag = doneFlag_ff;
        if (wrAcc) begin
            if (idx == ssp_pkg::IDX_OP_TYPE) begin
                nxt_opType = wByte;
                // Only a known code arms the sequence
                if (wByte == ssp_pkg::CODE_ERASE || wByte == ssp_pkg::CODE_PROGRAM) begin // see RQ1
                    nxt_seq = ssp_pkg::SEQ_TYPED;
                    nxt_erase = (wByte == ssp_pkg::CODE_ERASE); // see RQ1
                end else begin
                    nxt_seq = ssp_pkg::SEQ_IDLE;
                end
            end else if (idx == ssp_pkg::IDX_UNLOCK1) begin
                nxt_key1 = wNib;
                if (seq_ff == ssp_pkg::SEQ_TYPED && wNib == ssp_pkg::KEY_FIRST) begin // see RQ2 see RQ7
                    nxt_seq = ssp_pkg::SEQ_KEY1;
                end else begin
                    nxt_seq = ssp_pkg::SEQ_IDLE;
                    nxt_abort = 1'b1; // see RQ2
                end
            end else if (idx == ssp_pkg::IDX_UNLOCK2) begin
                nxt_key2 = wNib;
                if (seq_ff == ssp_pkg::SEQ_KEY1 && wNib == ssp_pkg::KEY_SECOND) begin // see RQ3
                    nxt_seq = ssp_pkg::SEQ_KEY2;
                end else begin
                    nxt_seq = ssp_pkg::SEQ_IDLE;
                    nxt_abort = 1'b1; // see RQ3
                end
            end else if (idx == ssp_pkg::IDX_UNLOCK3) begin
                nxt_key3 = wNib;
                if (seq_ff == ssp_pkg::SEQ_KEY2 && wNib == ssp_pkg::KEY_THIRD) begin // see RQ4
                    nxt_seq = ssp_pkg::SEQ_KEY3;
                end else begin
                    nxt_seq = ssp_pkg::SEQ_IDLE;
                    nxt_abort = 1'b1; // see RQ4
                end
            end else if (idx == ssp_pkg::IDX_UNLOCK4) begin
                nxt_key4 = wNib;
                nxt_seq = ssp_pkg::SEQ_IDLE; // Each operation needs a fresh sequence, see RQ12
                if (seq_ff == ssp_pkg::SEQ_KEY3 && wNib == ssp_pkg::KEY_FOURTH) begin // see RQ5 see RQ19
                    if (erase_ff && page_ff[ssp_pkg::PAGE_SECT_HI:ssp_pkg::PAGE_SECT_LO] == LAST_SECTOR) begin
                        nxt_refused = 1'b1; // see RQ17
                    end else begin
                        nxt_start = 1'b1; // see RQ19
                    end
                end else begin
                    nxt_abort = 1'b1; // see RQ5
                end
            end else if (idx == ssp_pkg::IDX_PAGE) begin
                nxt_page = wByte;
            end else if (idx == ssp_pkg::IDX_OFFSET) begin
                nxt_offset = wByte;
            end else if (idx == ssp_pkg::IDX_DATA) begin
                nxt_data = wByte;
            end else if (idx == ssp_pkg::IDX_AUX) begin
                nxt_aux = wByte;
            end else if (idx == ssp_pkg::IDX_STATUS) begin
                // Write one to clear sticky flags
                if (avs_writedata[ssp_pkg::ST_ABORT]) begin
                    nxt_abort = 1'b0;
                end
                if (avs_writedata[ssp_pkg::ST_REFUSED]) begin
                    nxt_refused = 1'b0;
                end
                if (avs_writedata[ssp_pkg::ST_DONE]) begin
                    nxt_doneFlag = 1'b0;
                end
            end
        end
        // Completion set wins over a clear in the same cycle
        if (fif.done) begin
            nxt_doneFlag = 1'b1;
        end
    end

    // Every reset disarms the sequence and zeroes the flow registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            opType_ff <= ssp_pkg::REG_RESET; // see RQ20
            key1_ff <= 4'h0;
            key2_ff <= 4'h0;
            key3_ff <= 4'h0;
            key4_ff <= 4'h0;
            page_ff <= ssp_pkg::REG_RESET;
            offset_ff <= ssp_pkg::REG_RESET;
            data_ff <= ssp_pkg::REG_RESET;
            aux_ff <= ssp_pkg::REG_RESET;
            seq_ff <= ssp_pkg::SEQ_IDLE; // see RQ20
            start_ff <= 1'b0;
            erase_ff <= 1'b0;
            abort_ff <= 1'b0;
            refused_ff <= 1'b0;
            doneFlag_ff <= 1'b0;
        end else begin
            opType_ff <= nxt_opType;
            key1_ff <= nxt_key1;
            key2_ff <= nxt_key2;
            key3_ff <= nxt_key3;
            key4_ff <= nxt_key4;
            page_ff <= nxt_page;
            offset_ff <= nxt_offset;
            data_ff <= nxt_data;
            aux_ff <= nxt_aux;
            seq_ff <= nxt_seq;
            start_ff <= nxt_start;
            erase_ff <= nxt_erase;
            abort_ff <= nxt_abort;
            refused_ff <= nxt_refused;
            doneFlag_ff <= nxt_doneFlag;
        end
    end

    // Flash address: sector and high offset from page, low offset byte
    assign fif.start = start_ff;
    assign fif.erase = erase_ff;
    assign fif.addr = {page_ff, offset_ff}; // see RQ15 see RQ16
    assign fif.data = data_ff; // see RQ16
    assign avs_readdata = {24'h000000, rdData_ff};

    ssp_flash_engine u_engine (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .op(fif.engine),
        .flashEraseReq(flashEraseReq),
        .flashProgReq(flashProgReq),
        .flashAddr(flashAddr),
        .flashData(flashData),
        .flashDone(flashDone),
        .cpuIdle(cpuIdle)
    );
endmodule

/* src/ssp_pkg.sv */
// Constants, register map and types of the self sector programming controller
// Notes on behaviour
// RQ1 - Operation type 0xE6 selects sector erase, 0x6E selects byte programming.
// RQ2 - First unlock register must get 05H, otherwise the attempt is terminated.
// RQ3 - Second unlock register must get 0AH, otherwise the attempt is terminated.
// RQ4 - Third unlock register must get 09H, otherwise the attempt is terminated.
// RQ5 - Fourth unlock register must get 06H, otherwise the attempt is terminated.
// RQ6 - Software disables interrupts, loads page and offset, then the data byte.
// RQ7 - Software then writes operation type and the four unlock registers in order.
// RQ8 - Software should run four no-operation instructions after the last unlock write.
// RQ9 - During a byte program the processor is held idle, then resumed.
// RQ10 - Each further byte needs data reload and a fresh type and unlock sequence.
// RQ11 - For erase, software disables interrupts and loads only the page register.
// RQ12 - During sector erase the processor is idle; each sector needs a fresh sequence.
// RQ13 - Afterwards software clears page and register A7H, then may enable interrupts.
// RQ14 - Software clears register A7H before any self programming.
// RQ15 - Page bits 7-2 give the sector, bits 1-0 the high offset bits.
// RQ16 - Offset register gives the low offset byte, data register the byte to program.
// RQ17 - Erase of the last sector, sector 15, is refused.
// RQ18 - Software never reprograms a programmed location before its sector is erased.
// RQ19 - Operation starts only after a fully correct sequence; aborts leave flash untouched.
// RQ20 - Type and unlock registers reset to zero on every reset.
package ssp_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int IDX_HI = 9;
    localparam int IDX_LO = 2;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_OP_TYPE = 8'hF2;
    localparam logic [7:0] IDX_UNLOCK1 = 8'hF3;
    localparam logic [7:0] IDX_UNLOCK2 = 8'hF4;
    localparam logic [7:0] IDX_UNLOCK3 = 8'hF5;
    localparam logic [7:0] IDX_UNLOCK4 = 8'hF6;
    localparam logic [7:0] IDX_PAGE = 8'hF7;
    localparam logic [7:0] IDX_STATUS = 8'hF8;
    localparam logic [7:0] IDX_OFFSET = 8'hFB;
    localparam logic [7:0] IDX_DATA = 8'hFC;
    localparam logic [7:0] IDX_AUX = 8'hA7;
    // Operation codes and unlock keys
    localparam logic [7:0] CODE_ERASE = 8'hE6;
    localparam logic [7:0] CODE_PROGRAM = 8'h6E;
    localparam logic [3:0] KEY_FIRST = 4'h5;
    localparam logic [3:0] KEY_SECOND = 4'hA;
    localparam logic [3:0] KEY_THIRD = 4'h9;
    localparam logic [3:0] KEY_FOURTH = 4'h6;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [5:0] LAST_SECTOR = 6'h0F;
    // Page field layout
    localparam int PAGE_SECT_HI = 7;
    localparam int PAGE_SECT_LO = 2;
    localparam int PAGE_OFFS_HI = 1;
    // Status bits
    localparam int ST_BUSY = 0;
    localparam int ST_ABORT = 1;
    localparam int ST_REFUSED = 2;
    localparam int ST_DONE = 3;
    localparam int FLASH_ADDR_W = 16;

    typedef enum logic [2:0] {SEQ_IDLE, SEQ_TYPED, SEQ_KEY1, SEQ_KEY2, SEQ_KEY3} ssp_seq_t;
    typedef enum logic [0:0] {ENG_IDLE, ENG_RUN} ssp_eng_t;
endpackage

/* src/ssp_flash_if.sv */
// Link between the register side and the flash operation engine
`timescale 1ns/1ps
interface ssp_flash_if;
    logic start;
    logic erase;
    logic [ssp_pkg::FLASH_ADDR_W-1:0] addr;
    logic [7:0] data;
    logic busy;
    logic done;
    modport ctrl (output start, output erase, output addr, output data, input busy, input done);
    modport engine (input start, input erase, input addr, input data, output busy, output done);
endinterface

/* src/ssp_flash_engine.sv */
// Flash operation engine: drives the array request and holds the processor idle
`timescale 1ns/1ps
module ssp_flash_engine (
    input wire logic clk_sys,
    input wire logic rst_b,
    ssp_flash_if.engine op,
    output logic flashEraseReq,
    output logic flashProgReq,
    output logic [ssp_pkg::FLASH_ADDR_W-1:0] flashAddr,
    output logic [7:0] flashData,
    input wire logic flashDone,
    output logic cpuIdle
);
    ssp_pkg::ssp_eng_t state_ff, nxt_state;
    logic eraseReq_ff, nxt_eraseReq;
    logic progReq_ff, nxt_progReq;
    logic [ssp_pkg::FLASH_ADDR_W-1:0] addr_ff, nxt_addr;
    logic [7:0] data_ff, nxt_data;
    logic done_ff, nxt_done;

    // Latch the operation and hold the request until the array reports done
    always_comb begin
        nxt_state = state_ff;
        nxt_eraseReq = eraseReq_ff;
        nxt_progReq = progReq_ff;
        nxt_addr = addr_ff;
        nxt_data = data_ff;
        nxt_done = 1'b0;
        case (state_ff)
            ssp_pkg::ENG_IDLE: begin
                if (op.start) begin
                    nxt_state = ssp_pkg::ENG_RUN;
                    nxt_eraseReq = op.erase;
                    nxt_progReq = !op.erase;
                    nxt_addr = op.addr; // see RQ15
                    nxt_data = op.data; // see RQ16
                end
            end
            ssp_pkg::ENG_RUN: begin
                if (flashDone) begin
                    nxt_state = ssp_pkg::ENG_IDLE;
                    nxt_eraseReq = 1'b0;
                    nxt_progReq = 1'b0;
                    nxt_done = 1'b1;
                end
            end
            default: nxt_state = ssp_pkg::ENG_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ssp_pkg::ENG_IDLE;
            eraseReq_ff <= 1'b0;
            progReq_ff <= 1'b0;
            addr_ff <= '0;
            data_ff <= ssp_pkg::REG_RESET;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            eraseReq_ff <= nxt_eraseReq;
            progReq_ff <= nxt_progReq;
            addr_ff <= nxt_addr;
            data_ff <= nxt_data;
            done_ff <= nxt_done;
        end
    end

    // Processor sleeps for the whole operation, erase or program
    assign cpuIdle = (state_ff == ssp_pkg::ENG_RUN); // see RQ9 see RQ12
    assign op.busy = cpuIdle;
    assign op.done = done_ff;
    assign flashEraseReq = eraseReq_ff;
    assign flashProgReq = progReq_ff;
    assign flashAddr = addr_ff;
    assign flashData = data_ff;
endmodule

/* testbench/ssp_ctrl_chk.sv */
// Port-level assertions and covers of the self sector programming controller
`timescale 1ns/1ps
module ssp_ctrl_chk #(
    parameter logic [5:0] LAST_SECTOR = ssp_pkg::LAST_SECTOR
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [ssp_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [ssp_pkg::DATA_W-1:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic flashEraseReq,
    input wire logic flashProgReq,
    input wire logic [ssp_pkg::FLASH_ADDR_W-1:0] flashAddr,
    input wire logic [7:0] flashData,
    input wire logic flashDone,
    input wire logic cpuIdle
);
    logic busyNow;
    logic keyHit;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    // An operation runs while either request stands
    assign busyNow = flashEraseReq | flashProgReq;
    // Final key taken by the bus; a start may only follow this
    assign keyHit = avs_write & !avs_waitrequest & (avs_address[9:2] == ssp_pkg::IDX_UNLOCK4)
        & (avs_writedata[3:0] == ssp_pkg::KEY_FOURTH);
    AST_ONE_OP: assert property (!(flashEraseReq && flashProgReq)) else $error("erase and program at once");
    AST_IDLE_TRACKS: assert property (cpuIdle == busyNow) else $error("idle differs from request");
    AST_STALL_BUSY: assert property (cpuIdle && avs_write |-> avs_waitrequest)
        else $error("write accepted while processor idle");
    AST_END_ON_DONE: assert property (busyNow && flashDone |=> !busyNow && !cpuIdle)
        else $error("operation outlived done");
    AST_HOLD_TARGET: assert property (busyNow && !flashDone |=> busyNow && $stable(flashAddr) && $stable(flashData))
        else $error("target moved during operation");
    AST_START_KEYED: assert property ($rose(busyNow) |-> $past(keyHit, 2))
        else $error("start without final key");
    AST_NO_LAST_ERASE: assert property ($rose(flashEraseReq) |-> flashAddr[15:10] != LAST_SECTOR)
        else $error("last sector erased");
    AST_RESET_QUIET: assert property (!$past(rst_b) |-> !busyNow && !cpuIdle)
        else $error("operation armed after reset");
    AST_READ_SWIFT: assert property (avs_read |-> ##[0:1] !avs_waitrequest) else $error("read stalled");
    // Main scenarios reached
    cover property ($rose(flashProgReq));
    cover property ($rose(flashEraseReq));
    cover property (cpuIdle && avs_write && avs_waitrequest);
endmodule
bind ssp_ctrl ssp_ctrl_chk #(.LAST_SECTOR(LAST_SECTOR)) chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .flashEraseReq(flashEraseReq), .flashProgReq(flashProgReq),
    .flashAddr(flashAddr), .flashData(flashData), .flashDone(flashDone), .cpuIdle(cpuIdle));

/* testbench/ssp_flash_model.sv */
// Behavioural flash array answering erase and program requests
`timescale 1ns/1ps
module ssp_flash_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic flashEraseReq,
    input wire logic flashProgReq,
    input wire logic [ssp_pkg::FLASH_ADDR_W-1:0] flashAddr,
    input wire logic [7:0] flashData,
    input wire logic [7:0] latency,
    output logic flashDone
);
    logic [7:0] mem [0:16383];
    logic [7:0] waitCnt;
    int opCount;
    int reprogCount;
    // Array starts erased
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        opCount = 0;
        reprogCount = 0;
    end
    // Done after a settable delay; one-cycle pulse so no second operation is ended
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            flashDone <= 1'b0;
            waitCnt <= 8'h00;
        end else if ((flashEraseReq || flashProgReq) && !flashDone) begin
            if (waitCnt >= latency) begin
                flashDone <= 1'b1;
                waitCnt <= 8'h00;
                opCount++;
                if (flashEraseReq) begin
                    for (int i = 0; i < 1024; i++) mem[{flashAddr[13:10], 10'(i)}] = 8'hFF;
                end else begin
                    if (mem[flashAddr[13:0]] !== 8'hFF) reprogCount++;
                    mem[flashAddr[13:0]] = flashData;
                end
            end else begin
                waitCnt <= waitCnt + 8'h01;
            end
        end else begin
            flashDone <= 1'b0;
            waitCnt <= 8'h00;
        end
    end
endmodule

/* testbench/ssp_ctrl_test.sv */
// Self-checking bench of the self sector programming controller
`timescale 1ns/1ps
module ssp_ctrl_test;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [ssp_pkg::ADDR_W-1:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [ssp_pkg::DATA_W-1:0] avs_writedata = 32'h00000000;
    logic [ssp_pkg::DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic flashEraseReq;
    logic flashProgReq;
    logic [ssp_pkg::FLASH_ADDR_W-1:0] flashAddr;
    logic [7:0] flashData;
    logic flashDone;
    logic cpuIdle;
    logic [7:0] latency = 8'h01;
    logic [7:0] rd;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;
    int ops;
    // 100 MHz system clock
    always #5 clk_sys = ~clk_sys;
    ssp_ctrl #(.LAST_SECTOR(6'h0F)) DUT (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flashEraseReq(flashEraseReq),
        .flashProgReq(flashProgReq), .flashAddr(flashAddr), .flashData(flashData), .flashDone(flashDone),
        .cpuIdle(cpuIdle));
    ssp_flash_model FLASH (.clk_sys(clk_sys), .rst_b(rst_b), .flashEraseReq(flashEraseReq),
        .flashProgReq(flashProgReq), .flashAddr(flashAddr), .flashData(flashData), .latency(latency),
        .flashDone(flashDone));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded run; a hang counts as a mismatch
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            $display("wrong value at %0t: run timed out", $time);
            report_and_stop();
        end
    end
    // One bus access; held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] val);
        @(posedge clk_sys);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, val};
        avs_write <= wr;
        avs_read <= !wr;
        // Values read here are those sampled at this edge, before its updates land
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // Type then four keys in order, the key at position bad spoilt when bad is below 4
    task automatic keys(input logic [7:0] typ, input int bad);
        logic [3:0] k [4] = '{ssp_pkg::KEY_FIRST, ssp_pkg::KEY_SECOND, ssp_pkg::KEY_THIRD, ssp_pkg::KEY_FOURTH};
        ops = FLASH.opCount;
        bus(1'b1, ssp_pkg::IDX_OP_TYPE, typ);
        for (int i = 0; i < 4; i++) bus(1'b1, 8'(ssp_pkg::IDX_UNLOCK1 + i), {4'h0, (i == bad) ? ~k[i] : k[i]});
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic idle_wait();
        for (int n = 0; n < 200 && cpuIdle !== 1'b0; n++) @(negedge clk_sys);
    endtask
    task automatic t_reset();
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, 8'(ssp_pkg::IDX_OP_TYPE + i), 8'h00);
            chk8(rd, ssp_pkg::REG_RESET);
        end
        bus(1'b0, 8'h10, 8'h00);
        chk8(rd, 8'h00);
        $display("test reset values done");
    endtask
    task automatic t_program();
        latency <= 8'h14;
        bus(1'b1, ssp_pkg::IDX_AUX, 8'h00);
        bus(1'b1, ssp_pkg::IDX_PAGE, 8'h1B);
        bus(1'b1, ssp_pkg::IDX_OFFSET, 8'hA5);
        bus(1'b1, ssp_pkg::IDX_DATA, 8'h3C);
        keys(ssp_pkg::CODE_PROGRAM, 4);
        chk8({7'h00, cpuIdle}, 8'h01);
        chk8(flashAddr[15:8], 8'h1B);
        chk8(flashAddr[7:0], 8'hA5);
        chk8(flashData, 8'h3C);
        // This write stalls while the processor is held idle
        bus(1'b1, ssp_pkg::IDX_AUX, 8'h00);
        chk8({7'h00, cpuIdle}, 8'h00);
        chk8(FLASH.mem[14'h1BA5], 8'h3C);
        latency <= 8'h01;
        bus(1'b1, ssp_pkg::IDX_OFFSET, 8'hA6);
        bus(1'b1, ssp_pkg::IDX_DATA, 8'h5A);
        // Clear done so the later read shows this completion, not the first
        bus(1'b1, ssp_pkg::IDX_STATUS, 8'h0E);
        keys(ssp_pkg::CODE_PROGRAM, 4);
        idle_wait();
        chk8(FLASH.mem[14'h1BA6], 8'h5A);
        bus(1'b0, ssp_pkg::IDX_STATUS, 8'h00);
        chk8({7'h00, rd[ssp_pkg::ST_DONE]}, 8'h01);
        $display("test byte program done");
    endtask
    task automatic t_erase();
        bus(1'b1, ssp_pkg::IDX_PAGE, 8'h18);
        keys(ssp_pkg::CODE_ERASE, 4);
        idle_wait();
        chk8(FLASH.mem[14'h1BA5], 8'hFF);
        chk8(8'(FLASH.opCount), 8'(ops + 1));
        bus(1'b1, ssp_pkg::IDX_PAGE, 8'h3C);
        keys(ssp_pkg::CODE_ERASE, 4);
        chk8(8'(FLASH.opCount), 8'(ops));
        bus(1'b0, ssp_pkg::IDX_STATUS, 8'h00);
        chk8({7'h00, rd[ssp_pkg::ST_REFUSED]}, 8'h01);
        bus(1'b1, ssp_pkg::IDX_STATUS, 8'h0E);
        chk8(FLASH.reprogCount[7:0], 8'h00);
        $display("test sector erase done");
    endtask
    task automatic t_badkey();
        bus(1'b1, ssp_pkg::IDX_PAGE, 8'h04);
        for (int b = 0; b < 4; b++) begin
            keys(ssp_pkg::CODE_PROGRAM, b);
            chk8(8'(FLASH.opCount), 8'(ops));
            bus(1'b0, ssp_pkg::IDX_STATUS, 8'h00);
            chk8({7'h00, rd[ssp_pkg::ST_ABORT]}, 8'h01);
            bus(1'b1, ssp_pkg::IDX_STATUS, 8'h0E);
        end
        keys(8'h00, 4);
        chk8(8'(FLASH.opCount), 8'(ops));
        $display("test wrong keys done");
    endtask
    task automatic t_midreset();
        ops = FLASH.opCount;
        bus(1'b1, ssp_pkg::IDX_OP_TYPE, ssp_pkg::CODE_PROGRAM);
        bus(1'b1, ssp_pkg::IDX_UNLOCK1, 8'h05);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        // Correct remaining keys: only the reset stands between them and a start
        bus(1'b1, ssp_pkg::IDX_UNLOCK2, {4'h0, ssp_pkg::KEY_SECOND});
        bus(1'b1, ssp_pkg::IDX_UNLOCK3, {4'h0, ssp_pkg::KEY_THIRD});
        bus(1'b1, ssp_pkg::IDX_UNLOCK4, {4'h0, ssp_pkg::KEY_FOURTH});
        repeat (4) @(posedge clk_sys);
        chk8(8'(FLASH.opCount), 8'(ops));
        bus(1'b0, ssp_pkg::IDX_STATUS, 8'h00);
        chk8({7'h00, rd[ssp_pkg::ST_ABORT]}, 8'h01);
        bus(1'b1, ssp_pkg::IDX_STATUS, 8'h0E);
        bus(1'b0, ssp_pkg::IDX_OP_TYPE, 8'h00);
        chk8(rd, 8'h00);
        bus(1'b1, ssp_pkg::IDX_PAGE, 8'h00);
        bus(1'b1, ssp_pkg::IDX_AUX, 8'h00);
        $display("test reset in sequence done");
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
        t_program();
        t_erase();
        t_badkey();
        t_midreset();
        report_and_stop();
    end
endmodule
